// >>> core/mdsr_offset_apply.sv
// Per-phase current feedback offset subtraction with registered outputs
`timescale 1ns/1ns
module mdsr_offset_apply
  import mdsr_pkg::*;
#(
  parameter int unsigned SW = SAMPLE_W
) (
  // Clock and reset
  input  wire logic          core_clk_i,
  input  wire logic          rst_b_i,
  // Control
  input  wire logic          offset_apply_enable_i,
  // Raw samples
  input  wire logic          sample_valid_i,
  input  wire logic [SW-1:0] v_raw_i,
  input  wire logic [SW-1:0] w_raw_i,
  // Stored offsets
  input  wire logic [SW-1:0] v_phase_offset_i,
  input  wire logic [SW-1:0] w_phase_offset_i,
  // Corrected samples
  output logic               corr_valid_o,
  output logic [SW-1:0]      v_corr_o,
  output logic [SW-1:0]      w_corr_o
);

  logic [1:0][SW-1:0] raw;
  logic [1:0][SW-1:0] ofs;
  logic [SW-1:0]      corr [2];  // Unpacked so each phase process owns its own word

  assign raw = {w_raw_i, v_raw_i};
  assign ofs = {w_phase_offset_i, v_phase_offset_i};
  assign v_corr_o = corr[0];
  assign w_corr_o = corr[1];

  // ==========================================================================
  // One subtractor per phase; wraps modulo the sample width
  genvar g;
  for (g = 0; g < 2; g++) begin : g_phase
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        corr[g] <= '0;
      end else if (sample_valid_i) begin
        corr[g] <= offset_apply_enable_i ? SW'(raw[g] - ofs[g]) : raw[g];
      end
    end
  end

  // Valid follows the sample by one cycle
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      corr_valid_o <= 1'b0;
    end else begin
      corr_valid_o <= sample_valid_i;
    end
  end

  a_offset_sub: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    sample_valid_i && offset_apply_enable_i |=> v_corr_o == SW'($past(v_raw_i) - $past(v_phase_offset_i))
      && w_corr_o == SW'($past(w_raw_i) - $past(w_phase_offset_i)))
    else $error("corrected sample does not equal raw minus offset");

endmodule : mdsr_offset_apply

// >>> core/mdsr_pkg.sv
// Constants, register indices and types shared by the motor drive status readback bank
package mdsr_pkg;

  // ==========================================================================
  // Bus geometry
  localparam int unsigned AXI_AW  = 9;   // Highest index 0x7F times four fits
  localparam int unsigned AXI_DW  = 32;
  localparam int unsigned IDX_W   = 7;
  localparam int unsigned IDX_LSB = 2;   // Byte address is four times the index

  // ==========================================================================
  // Register indices, one aligned word each
  localparam logic [IDX_W-1:0] IDX_SPEED    = 7'h26;
  localparam logic [IDX_W-1:0] IDX_OFFS     = 7'h30;
  localparam logic [IDX_W-1:0] IDX_ENC      = 7'h34;
  localparam logic [IDX_W-1:0] IDX_EE_DATA  = 7'h39;
  localparam logic [IDX_W-1:0] IDX_EE_VER   = 7'h3A;
  localparam logic [IDX_W-1:0] IDX_EE_STAT  = 7'h3B;
  localparam logic [IDX_W-1:0] IDX_ANGLE    = 7'h3C;
  localparam logic [IDX_W-1:0] IDX_LOOP_REF = 7'h3E;
  localparam logic [IDX_W-1:0] IDX_LOOP_ERR = 7'h40;
  localparam logic [IDX_W-1:0] IDX_LOOP_OUT = 7'h42;
  localparam logic [IDX_W-1:0] IDX_SYS_CTRL = 7'h44;
  localparam logic [IDX_W-1:0] IDX_EE_CTRL  = 7'h45;
  localparam logic [IDX_W-1:0] IDX_PRODUCT  = 7'h7C;
  localparam logic [IDX_W-1:0] IDX_MAP_VER  = 7'h7D;
  localparam logic [IDX_W-1:0] IDX_REV      = 7'h7E;

  // ==========================================================================
  // Field widths and positions
  localparam int unsigned SAMPLE_W      = 12;
  localparam int unsigned HALF_W        = 16;
  localparam int unsigned BYTE_W        = 8;
  localparam int unsigned OFFS_W_LSB    = 12;  // W offset sits above V offset
  localparam int unsigned SYS_OFFS_EN   = 0;
  localparam int unsigned EE_STAT_BUSY  = 0;
  localparam int unsigned EE_STAT_VALID = 1;
  localparam int unsigned STRB_LANE0    = 0;

  // ==========================================================================
  // Responses and channel states
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    MDSR_IDLE = 2'b01,
    MDSR_BUSY = 2'b10
  } mdsr_chan_st_t;

endpackage : mdsr_pkg

// >>> core/mdsr_status_bank.sv
// AXI4-Lite readable status bank of the motor drive: speed, offsets, encoder, EEPROM and IDs
`timescale 1ns/1ns

module mdsr_status_bank
  import mdsr_pkg::*;
#(
  parameter logic [BYTE_W-1:0] PRODUCT_CODE   = 8'h5A,     // Arbitrary value
  parameter logic [BYTE_W-1:0] MAP_VERSION    = 8'h01,     // Arbitrary value
  parameter logic [HALF_W-1:0] LOGIC_REVISION = 16'h0100   // Arbitrary value, digits XX.XX
) (
  // Clock and reset
  input  wire logic                core_clk_i,
  input  wire logic                rst_b_i,
  // AXI4-Lite write address and data
  input  wire logic                awvalid_i,
  output logic                     awready_o,
  input  wire logic [AXI_AW-1:0]   awaddr_i,
  input  wire logic [2:0]          awprot_i,
  input  wire logic                wvalid_i,
  output logic                     wready_o,
  input  wire logic [AXI_DW-1:0]   wdata_i,
  input  wire logic [AXI_DW/8-1:0] wstrb_i,
  // AXI4-Lite write response
  output logic                     bvalid_o,
  input  wire logic                bready_i,
  output logic [1:0]               bresp_o,
  // AXI4-Lite read
  input  wire logic                arvalid_i,
  output logic                     arready_o,
  input  wire logic [AXI_AW-1:0]   araddr_i,
  input  wire logic [2:0]          arprot_i,
  output logic                     rvalid_o,
  input  wire logic                rready_i,
  output logic [AXI_DW-1:0]        rdata_o,
  output logic [1:0]               rresp_o,
  // Live values from the control core
  input  wire logic [HALF_W-1:0]   motor_speed_i,
  input  wire logic [AXI_DW-1:0]   encoder_count_wide_i,
  input  wire logic [HALF_W-1:0]   electrical_angle_i,
  input  wire logic [HALF_W-1:0]   speed_reference_i,
  input  wire logic [HALF_W-1:0]   speed_error_i,
  input  wire logic [HALF_W-1:0]   speed_loop_output_i,
  // Offset calculation result
  input  wire logic                offs_load_i,
  input  wire logic [SAMPLE_W-1:0] v_phase_offset_i,
  input  wire logic [SAMPLE_W-1:0] w_phase_offset_i,
  // Current feedback samples
  input  wire logic                sample_valid_i,
  input  wire logic [SAMPLE_W-1:0] v_raw_i,
  input  wire logic [SAMPLE_W-1:0] w_raw_i,
  output logic                     corr_valid_o,
  output logic [SAMPLE_W-1:0]      v_corr_o,
  output logic [SAMPLE_W-1:0]      w_corr_o,
  // EEPROM engine
  input  wire logic                eeprom_busy_flag_i,
  input  wire logic                ee_read_done_i,
  input  wire logic [BYTE_W-1:0]   ee_read_byte_i,
  input  wire logic [BYTE_W-1:0]   eeprom_version_readback_i,
  output logic                     eeprom_reset_field_o
);

  // ==========================================================================
  // Decode helpers
  function automatic logic [IDX_W-1:0] idx_of(input logic [AXI_AW-1:0] addr);
    idx_of = addr[IDX_LSB +: IDX_W];
  endfunction : idx_of

  function automatic logic idx_mapped(input logic [IDX_W-1:0] idx);
    case (idx)
      IDX_SPEED, IDX_OFFS, IDX_ENC, IDX_EE_DATA, IDX_EE_VER, IDX_EE_STAT,
      IDX_ANGLE, IDX_LOOP_REF, IDX_LOOP_ERR, IDX_LOOP_OUT, IDX_SYS_CTRL,
      IDX_EE_CTRL, IDX_PRODUCT, IDX_MAP_VER, IDX_REV: idx_mapped = 1'b1;
      default:                                        idx_mapped = 1'b0;
    endcase
  endfunction : idx_mapped

  // ==========================================================================
  // Stored state
  mdsr_chan_st_t       wr_st;
  mdsr_chan_st_t       rd_st;
  logic                offset_apply_enable;
  logic [SAMPLE_W-1:0] v_phase_offset;
  logic [SAMPLE_W-1:0] w_phase_offset;
  logic [BYTE_W-1:0]   eeprom_read_data;
  logic                ee_data_valid;
  logic [AXI_DW-1:0]   next_rdata;
  logic                wr_fire;
  logic [IDX_W-1:0]    wr_idx;
  logic [IDX_W-1:0]    rd_idx;

  assign wr_fire = awvalid_i && awready_o && wvalid_i && wready_o;
  assign wr_idx  = idx_of(awaddr_i);
  assign rd_idx  = idx_of(araddr_i);

  // ==========================================================================
  // Write channel: takes address and data together, then answers
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_st     <= MDSR_IDLE;
      awready_o <= 1'b0;
      wready_o  <= 1'b0;
      bvalid_o  <= 1'b0;
      bresp_o   <= RESP_OKAY;
    end else begin
      case (wr_st)
        MDSR_IDLE: begin
          if (wr_fire) begin
            awready_o <= 1'b0;
            wready_o  <= 1'b0;
            bvalid_o  <= 1'b1;
            bresp_o   <= idx_mapped(wr_idx) ? RESP_OKAY : RESP_SLVERR;
            wr_st     <= MDSR_BUSY;
          end else if (awvalid_i && wvalid_i) begin
            awready_o <= 1'b1;
            wready_o  <= 1'b1;
          end
        end
        MDSR_BUSY: begin
          if (bready_i) begin
            bvalid_o <= 1'b0;
            wr_st    <= MDSR_IDLE;
          end
        end
        default: begin
          awready_o <= 1'b0;
          wready_o  <= 1'b0;
          bvalid_o  <= 1'b0;
          wr_st     <= MDSR_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // Control words; status words ignore writes entirely
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      offset_apply_enable  <= 1'b0;
      eeprom_reset_field_o <= 1'b0;
    end else begin
      if (wr_fire && wr_idx == IDX_SYS_CTRL && wstrb_i[STRB_LANE0]) begin
        offset_apply_enable <= wdata_i[SYS_OFFS_EN];
      end
      // Any write at all counts, whatever the strobes, to keep reset simple for software
      eeprom_reset_field_o <= wr_fire && wr_idx == IDX_EE_CTRL;
    end
  end

  // ==========================================================================
  // Offsets from the most recent calculation
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      v_phase_offset <= '0;
      w_phase_offset <= '0;
    end else if (offs_load_i) begin
      v_phase_offset <= v_phase_offset_i;
      w_phase_offset <= w_phase_offset_i;
    end
  end

  // ==========================================================================
  // EEPROM read byte; a fresh read beats a same-cycle invalidation
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      eeprom_read_data <= '0;
      ee_data_valid    <= 1'b0;
    end else if (ee_read_done_i) begin
      eeprom_read_data <= ee_read_byte_i;
      ee_data_valid    <= 1'b1;
    end else if (wr_fire && wr_idx == IDX_EE_CTRL) begin
      eeprom_read_data <= '0;
      ee_data_valid    <= 1'b0;
    end
  end

  // ==========================================================================
  // Read mux; narrow fields sit low and the rest reads zero
  always_comb begin
    next_rdata = '0;
    case (rd_idx)
      IDX_SPEED:    next_rdata[HALF_W-1:0] = motor_speed_i;
      IDX_OFFS: begin
        next_rdata[SAMPLE_W-1:0]                = v_phase_offset;
        next_rdata[OFFS_W_LSB +: SAMPLE_W]      = w_phase_offset;
      end
      IDX_ENC:      next_rdata                  = encoder_count_wide_i;
      IDX_EE_DATA:  next_rdata[BYTE_W-1:0]      = eeprom_read_data;
      IDX_EE_VER:   next_rdata[BYTE_W-1:0]      = eeprom_version_readback_i;
      IDX_EE_STAT: begin
        next_rdata[EE_STAT_BUSY]                = eeprom_busy_flag_i;
        next_rdata[EE_STAT_VALID]               = ee_data_valid;
      end
      IDX_ANGLE:    next_rdata[HALF_W-1:0]      = electrical_angle_i;
      IDX_LOOP_REF: next_rdata[HALF_W-1:0]      = speed_reference_i;
      IDX_LOOP_ERR: next_rdata[HALF_W-1:0]      = speed_error_i;
      IDX_LOOP_OUT: next_rdata[HALF_W-1:0]      = speed_loop_output_i;
      IDX_SYS_CTRL: next_rdata[SYS_OFFS_EN]     = offset_apply_enable;
      IDX_PRODUCT:  next_rdata[BYTE_W-1:0]      = PRODUCT_CODE;
      IDX_MAP_VER:  next_rdata[BYTE_W-1:0]      = MAP_VERSION;
      IDX_REV:      next_rdata[HALF_W-1:0]      = LOGIC_REVISION;
      default:      next_rdata                  = '0;
    endcase
  end

  // ==========================================================================
  // Read channel: one cycle of arready, data captured at the handshake
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rd_st     <= MDSR_IDLE;
      arready_o <= 1'b0;
      rvalid_o  <= 1'b0;
      rdata_o   <= '0;
      rresp_o   <= RESP_OKAY;
    end else begin
      case (rd_st)
        MDSR_IDLE: begin
          if (arvalid_i && arready_o) begin
            arready_o <= 1'b0;
            rvalid_o  <= 1'b1;
            rdata_o   <= next_rdata;
            rresp_o   <= idx_mapped(rd_idx) ? RESP_OKAY : RESP_SLVERR;
            rd_st     <= MDSR_BUSY;
          end else if (arvalid_i) begin
            arready_o <= 1'b1;
          end
        end
        MDSR_BUSY: begin
          if (rready_i) begin
            rvalid_o <= 1'b0;
            rd_st    <= MDSR_IDLE;
          end
        end
        default: begin
          arready_o <= 1'b0;
          rvalid_o  <= 1'b0;
          rd_st     <= MDSR_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // Current feedback correction
  mdsr_offset_apply #(
    .SW (SAMPLE_W)
  ) u_offset_apply (
    .core_clk_i            (core_clk_i),
    .rst_b_i               (rst_b_i),
    .offset_apply_enable_i (offset_apply_enable),
    .sample_valid_i        (sample_valid_i),
    .v_raw_i               (v_raw_i),
    .w_raw_i               (w_raw_i),
    .v_phase_offset_i      (v_phase_offset),
    .w_phase_offset_i      (w_phase_offset),
    .corr_valid_o          (corr_valid_o),
    .v_corr_o              (v_corr_o),
    .w_corr_o              (w_corr_o)
  );

  // ==========================================================================
  // Checks
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);

  logic rd_take;
  assign rd_take = arvalid_i && arready_o;

  a_speed_read: assert property (
    rd_take && rd_idx == IDX_SPEED |=> rvalid_o && rdata_o == {16'h0000, $past(motor_speed_i)})
    else $error("speed read returned wrong value");

  a_offs_read: assert property (
    offs_load_i ##1 (!offs_load_i)[*3] ##0 rd_take && rd_idx == IDX_OFFS
      |=> rdata_o[SAMPLE_W-1:0] == $past(v_phase_offset_i, 4))
    else $error("offset read does not show last calculation");

  a_enc_read: assert property (
    rd_take && rd_idx == IDX_ENC |=> rdata_o == $past(encoder_count_wide_i))
    else $error("encoder count read mismatch");

  a_ee_hold: assert property (
    ee_read_done_i |=> eeprom_read_data == $past(ee_read_byte_i) && ee_data_valid)
    else $error("EEPROM read byte not loaded");

  a_ee_invalid: assert property (
    wr_fire && wr_idx == IDX_EE_CTRL && !ee_read_done_i |=> !ee_data_valid ##0 eeprom_reset_field_o)
    else $error("EEPROM reset write did not invalidate data");

  a_ver_read: assert property (
    rd_take && rd_idx == IDX_EE_VER |=> rdata_o == {24'h00_0000, $past(eeprom_version_readback_i)})
    else $error("version readback mismatch");

  a_rev_read: assert property (
    rd_take && rd_idx == IDX_REV |=> rdata_o == {16'h0000, LOGIC_REVISION})
    else $error("revision code read mismatch");

  a_diag_read: assert property (
    rd_take && rd_idx == IDX_LOOP_ERR |=> rdata_o == {16'h0000, $past(speed_error_i)})
    else $error("speed error read mismatch");

  a_id_read: assert property (
    rd_take && rd_idx == IDX_PRODUCT |=> rdata_o == {24'h00_0000, PRODUCT_CODE})
    else $error("product code read mismatch");

  a_status_kept: assert property (
    wr_fire && wr_idx != IDX_EE_CTRL && !ee_read_done_i && !offs_load_i
      |=> $stable(eeprom_read_data) && $stable(v_phase_offset) && $stable(w_phase_offset))
    else $error("write altered a status value");

  a_bresp_order: assert property (
    wr_fire |=> bvalid_o && !awready_o [*1] ##0 !wready_o)
    else $error("write response not raised after handshake");

  c_read_done: cover property (rd_take ##1 rvalid_o && rready_i);
  c_write_done: cover property (wr_fire ##1 bvalid_o && bready_i);
  c_ee_clash: cover property (wr_fire && wr_idx == IDX_EE_CTRL && ee_read_done_i);
  c_unmapped: cover property (rd_take && !idx_mapped(rd_idx));

endmodule : mdsr_status_bank

// >>> dv/tb.sv
// Self-checking bench for the motor drive status readback bank over AXI4-Lite
`timescale 1ns/1ns
module tb
  import mdsr_pkg::*;
;
  // ==========================================================================
  // Stimulus and observed signals
  logic                core_clk_i = 1'b0;
  logic                rst_b_i = 1'b0;
  logic                awvalid_i = 1'b0, wvalid_i = 1'b0, bready_i = 1'b0, arvalid_i = 1'b0, rready_i = 1'b0;
  logic [AXI_AW-1:0]   awaddr_i = '0, araddr_i = '0;
  logic [AXI_DW-1:0]   wdata_i = '0;
  logic [3:0]          wstrb_i = 4'hF;
  logic [2:0]          awprot_i = 3'h0, arprot_i = 3'h0;
  logic [HALF_W-1:0]   motor_speed_i = 16'h8E21, electrical_angle_i = 16'h0C3D, speed_reference_i = 16'h1F42;
  logic [HALF_W-1:0]   speed_error_i = 16'hF00B, speed_loop_output_i = 16'h7A5E;
  logic [AXI_DW-1:0]   encoder_count_wide_i = 32'hA5C3_1E7F;
  logic                offs_load_i = 1'b0, sample_valid_i = 1'b0;
  logic [SAMPLE_W-1:0] v_phase_offset_i = '0, w_phase_offset_i = '0, v_raw_i = '0, w_raw_i = '0;
  logic                eeprom_busy_flag_i = 1'b0, ee_read_done_i = 1'b0;
  logic [BYTE_W-1:0]   ee_read_byte_i = '0, eeprom_version_readback_i = 8'h6B;
  logic                awready_o, wready_o, bvalid_o, arready_o, rvalid_o, corr_valid_o, eeprom_reset_field_o;
  logic [1:0]          bresp_o, rresp_o;
  logic [AXI_DW-1:0]   rdata_o;
  logic [SAMPLE_W-1:0] v_corr_o, w_corr_o;
  int                  n_fail = 0;
  int                  samples_checked = 0;
  int                  n_ee_rst = 0;

  // ==========================================================================
  // Clock, device under test
  always #20 core_clk_i = ~core_clk_i;

  // Identification values are arbitrary
  mdsr_status_bank #(.PRODUCT_CODE(8'hA3), .MAP_VERSION(8'h02), .LOGIC_REVISION(16'h0213)) i_dut (
    .core_clk_i, .rst_b_i, .awvalid_i, .awready_o, .awaddr_i, .awprot_i, .wvalid_i, .wready_o, .wdata_i,
    .wstrb_i, .bvalid_o, .bready_i, .bresp_o, .arvalid_i, .arready_o, .araddr_i, .arprot_i, .rvalid_o,
    .rready_i, .rdata_o, .rresp_o, .motor_speed_i, .encoder_count_wide_i, .electrical_angle_i,
    .speed_reference_i, .speed_error_i, .speed_loop_output_i, .offs_load_i, .v_phase_offset_i,
    .w_phase_offset_i, .sample_valid_i, .v_raw_i, .w_raw_i, .corr_valid_o, .v_corr_o, .w_corr_o,
    .eeprom_busy_flag_i, .ee_read_done_i, .ee_read_byte_i, .eeprom_version_readback_i, .eeprom_reset_field_o
  );

  // Pulse counter, since the reset strobe lives inside a bus transfer
  always @(posedge core_clk_i) begin
    if (eeprom_reset_field_o === 1'b1) n_ee_rst <= n_ee_rst + 1;
  end

  // ==========================================================================
  // Verdict and comparison
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : close_out

  task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask : chk_word

  // A bound that runs out ends the run at once
  task automatic guard(input int n, input string nm);
    if (n >= 50) begin
      n_fail++;
      $display("CHECK FAILED %s exp answer got timeout", nm);
      close_out();
    end
  endtask : guard

  // ==========================================================================
  // Bus master tasks: start just after an edge, end one edge after the answer
  task automatic axi_write(input logic [IDX_W-1:0] idx, input logic [31:0] d, input logic [3:0] s,
                           input logic [1:0] exp_r);
    int         n;
    logic [1:0] r;
    n = 0;
    awvalid_i <= 1'b1;
    awaddr_i  <= {idx, 2'b00};
    wvalid_i  <= 1'b1;
    wdata_i   <= d;
    wstrb_i   <= s;
    bready_i  <= 1'b1;
    while (bvalid_o !== 1'b1 && n < 50) begin
      @(posedge core_clk_i);
      n++;
      if (awready_o === 1'b1) awvalid_i <= 1'b0;
      if (wready_o === 1'b1) wvalid_i <= 1'b0;
    end
    r = bresp_o;
    bready_i <= 1'b0;
    guard(n, "bvalid");
    chk_word($sformatf("bresp_%h", idx), 32'(exp_r), 32'(r));
    @(posedge core_clk_i);
  endtask : axi_write

  task automatic axi_read(input logic [IDX_W-1:0] idx, input logic [31:0] exp_d, input logic [1:0] exp_r);
    int          n;
    logic [31:0] d;
    logic [1:0]  r;
    n = 0;
    arvalid_i <= 1'b1;
    araddr_i  <= {idx, 2'b00};
    rready_i  <= 1'b1;
    while (rvalid_o !== 1'b1 && n < 50) begin
      @(posedge core_clk_i);
      n++;
      if (arready_o === 1'b1) arvalid_i <= 1'b0;
    end
    d = rdata_o;
    r = rresp_o;
    rready_i <= 1'b0;
    guard(n, "rvalid");
    chk_word($sformatf("rdata_%h", idx), exp_d, d);
    chk_word($sformatf("rresp_%h", idx), 32'(exp_r), 32'(r));
    @(posedge core_clk_i);
  endtask : axi_read

  // One current sample; corr_valid_o shows for exactly one cycle while the corrected value holds
  task automatic do_sample(input logic [11:0] v, input logic [11:0] w, input logic [11:0] ev,
                           input logic [11:0] ew);
    sample_valid_i <= 1'b1;
    v_raw_i        <= v;
    w_raw_i        <= w;
    @(posedge core_clk_i);
    sample_valid_i <= 1'b0;
    #1;
    chk_word("corr_valid", 32'h0000_0001, 32'(corr_valid_o));
    chk_word("v_corr", 32'(ev), 32'(v_corr_o));
    chk_word("w_corr", 32'(ew), 32'(w_corr_o));
    @(posedge core_clk_i);
    #1;
    chk_word("corr_valid_low", 32'h0000_0000, 32'(corr_valid_o));
    @(posedge core_clk_i);
  endtask : do_sample

  // ==========================================================================
  // Main sequence
  initial begin
    repeat (16) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    @(posedge core_clk_i);
    // Cleared state after reset
    axi_read(IDX_OFFS, 32'h0000_0000, RESP_OKAY);
    axi_read(IDX_EE_DATA, 32'h0000_0000, RESP_OKAY);
    axi_read(IDX_SYS_CTRL, 32'h0000_0000, RESP_OKAY);
    // Live values and IDs, upper bits zero except the full-width encoder count
    axi_read(IDX_SPEED, 32'h0000_8E21, RESP_OKAY);
    axi_read(IDX_ENC, 32'hA5C3_1E7F, RESP_OKAY);
    encoder_count_wide_i <= 32'hFFFF_FFFE;
    axi_read(IDX_ENC, 32'hFFFF_FFFE, RESP_OKAY);
    axi_read(IDX_ANGLE, 32'h0000_0C3D, RESP_OKAY);
    axi_read(IDX_LOOP_REF, 32'h0000_1F42, RESP_OKAY);
    axi_read(IDX_LOOP_ERR, 32'h0000_F00B, RESP_OKAY);
    axi_read(IDX_LOOP_OUT, 32'h0000_7A5E, RESP_OKAY);
    axi_read(IDX_PRODUCT, 32'h0000_00A3, RESP_OKAY);
    axi_read(IDX_MAP_VER, 32'h0000_0002, RESP_OKAY);
    axi_read(IDX_REV, 32'h0000_0213, RESP_OKAY);
    axi_read(IDX_EE_VER, 32'h0000_006B, RESP_OKAY);
    // Writes to status words are accepted but ignored; holes give an error
    axi_write(IDX_SPEED, 32'hFFFF_FFFF, 4'hF, RESP_OKAY);
    axi_read(IDX_SPEED, 32'h0000_8E21, RESP_OKAY);
    axi_write(IDX_REV, 32'h0000_0000, 4'hF, RESP_OKAY);
    axi_read(IDX_REV, 32'h0000_0213, RESP_OKAY);
    axi_read(7'h01, 32'h0000_0000, RESP_SLVERR);
    axi_write(7'h50, 32'h0000_0001, 4'hF, RESP_SLVERR);
    // Offsets are captured on load and held afterwards
    offs_load_i      <= 1'b1;
    v_phase_offset_i <= 12'h010;
    w_phase_offset_i <= 12'h020;
    @(posedge core_clk_i);
    offs_load_i      <= 1'b0;
    v_phase_offset_i <= 12'h777;
    @(posedge core_clk_i);
    axi_read(IDX_OFFS, 32'h0002_0010, RESP_OKAY);
    // Strobe lane 0 off must leave the enable untouched
    axi_write(IDX_SYS_CTRL, 32'h0000_0001, 4'hE, RESP_OKAY);
    axi_read(IDX_SYS_CTRL, 32'h0000_0000, RESP_OKAY);
    axi_write(IDX_SYS_CTRL, 32'h0000_0001, 4'h1, RESP_OKAY);
    axi_read(IDX_SYS_CTRL, 32'h0000_0001, RESP_OKAY);
    do_sample(12'h005, 12'h100, 12'hFF5, 12'h0E0);
    do_sample(12'h800, 12'h020, 12'h7F0, 12'h000);
    axi_write(IDX_SYS_CTRL, 32'h0000_0000, 4'hF, RESP_OKAY);
    do_sample(12'h005, 12'h100, 12'h005, 12'h100);
    // EEPROM: poll busy, capture a read byte, then invalidate it
    eeprom_busy_flag_i <= 1'b1;
    axi_read(IDX_EE_STAT, 32'h0000_0001, RESP_OKAY);
    eeprom_busy_flag_i <= 1'b0;
    axi_read(IDX_EE_STAT, 32'h0000_0000, RESP_OKAY);
    ee_read_done_i <= 1'b1;
    ee_read_byte_i <= 8'hC7;
    @(posedge core_clk_i);
    ee_read_done_i <= 1'b0;
    ee_read_byte_i <= 8'h38;
    @(posedge core_clk_i);
    axi_read(IDX_EE_DATA, 32'h0000_00C7, RESP_OKAY);
    axi_read(IDX_EE_STAT, 32'h0000_0002, RESP_OKAY);
    axi_write(IDX_EE_CTRL, 32'h0000_0001, 4'hF, RESP_OKAY);
    chk_word("ee_reset_pulses", 32'h0000_0001, 32'(n_ee_rst));
    axi_read(IDX_EE_DATA, 32'h0000_0000, RESP_OKAY);
    axi_read(IDX_EE_STAT, 32'h0000_0000, RESP_OKAY);
    close_out();
  end
endmodule : tb
